// ===== include/sfqm_defines.svh
// constants of the serial flash quad mode and capability block
`ifndef SFQM_DEFINES_SVH
`define SFQM_DEFINES_SVH

// ----------------------------------------------------------------
// serial opcodes
// ----------------------------------------------------------------
`define SFQM_OP_RD_STAT1 8'h05
`define SFQM_OP_RD_STAT2 8'h35
`define SFQM_OP_WR_STAT 8'h01
`define SFQM_OP_RD_CAPS 8'h5A
`define SFQM_OP_QUAD_RD 8'hEB

// ----------------------------------------------------------------
// continuous quad read mode byte
// ----------------------------------------------------------------
`define SFQM_MODE_ENTER 8'hA5
`define SFQM_MODE_STAY_NIB 4'hA
`define SFQM_MODE_EXIT 8'h00
`define SFQM_EXIT_NIB 4'hF
`define SFQM_EXIT_CLKS 4'd8

// ----------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------
`define SFQM_WIP_BIT 0
`define SFQM_QE_BIT 1

// ----------------------------------------------------------------
// phase lengths in serial clocks
// ----------------------------------------------------------------
`define SFQM_CMD_CLKS 5'd8
`define SFQM_QADR_CLKS 5'd6
`define SFQM_QMODE_CLKS 5'd2
`define SFQM_QDMY_CLKS 5'd4
`define SFQM_QBYTE_CLKS 5'd2
`define SFQM_SADR_CLKS 5'd24
`define SFQM_SDMY_CLKS 5'd8
`define SFQM_SBYTE_CLKS 5'd8
`define SFQM_WSR_CLKS 5'd16

// ----------------------------------------------------------------
// capability words: byte addresses and fields
// ----------------------------------------------------------------
`define SFQM_CAP_DW14_ADDR 8'h34
`define SFQM_CAP_DW15_ADDR 8'h38
`define SFQM_CAP_FILL 8'hFF
`define SFQM_DPD_UNSUP 1'b1
`define SFQM_DPD_ENTER_OP 8'hFF
`define SFQM_DPD_EXIT_OP 8'hFF
`define SFQM_DPD_UNIT_128NS 2'b00
`define SFQM_DPD_UNIT_1US 2'b01
`define SFQM_DPD_UNIT_8US 2'b10
`define SFQM_DPD_UNIT_64US 2'b11
`define SFQM_DPD_COUNT 5'b1_1111
`define SFQM_RSV_NIB 4'hF
`define SFQM_POLL_LEGACY 2'b01
`define SFQM_RSV_LOW 2'b11
`define SFQM_RSV_BYTE 8'hFF
`define SFQM_HOLD_WP_DIS 1'b0
`define SFQM_QE_REQ 3'b101
`define SFQM_ENTRY_METHOD 4'b1101
`define SFQM_EXIT_METHOD 6'b11_1101
`define SFQM_DW15_LOW 10'h200

// ----------------------------------------------------------------
// software register port
// ----------------------------------------------------------------
`define SFQM_REG_CTRL 4'h0
`define SFQM_REG_STATE 4'h4
`define SFQM_ST_CONT_BIT 2

`endif

// ===== include/sfqm_pkg.sv
// types of the serial flash quad mode and capability block
package sfqm_pkg;

	// serial transaction phases
	typedef enum logic [3:0] {
		SFQM_IDLE  = 4'b0000,
		SFQM_CMD   = 4'b0001,
		SFQM_RD1   = 4'b0010,
		SFQM_RD2   = 4'b0011,
		SFQM_WSR   = 4'b0100,
		SFQM_SADR  = 4'b0101,
		SFQM_SDMY  = 4'b0110,
		SFQM_SDATA = 4'b0111,
		SFQM_QADR  = 4'b1000,
		SFQM_QMODE = 4'b1001,
		SFQM_QDMY  = 4'b1010,
		SFQM_QDATA = 4'b1011,
		SFQM_SKIP  = 4'b1100
	} sfqm_state_t;

endpackage

// ===== src/sfqm_caps_rom.sv
// read-only capability words served by the capability read
`timescale 1ns/1ps
`default_nettype none
`include "sfqm_defines.svh"

module sfqm_caps_rom (
	// byte address within the capability table
	input wire logic [7:0] i_addr,
	// byte at that address
	output logic [7:0] o_byte
);

	logic [31:0] dw14;
	logic [31:0] dw15;

	// ------------------------------------------------------------
	// fixed words, no state, nothing can alter them
	// ------------------------------------------------------------
	// deep power down word
	assign dw14 = {`SFQM_DPD_UNSUP,
		`SFQM_DPD_ENTER_OP, `SFQM_DPD_EXIT_OP,
		`SFQM_DPD_UNIT_64US,
		`SFQM_DPD_COUNT,
		`SFQM_RSV_NIB,
		`SFQM_POLL_LEGACY,
		`SFQM_RSV_LOW};

	// quad enable and continuous mode word
	assign dw15 = {`SFQM_RSV_BYTE,
		`SFQM_HOLD_WP_DIS,
		`SFQM_QE_REQ,
		`SFQM_ENTRY_METHOD,
		`SFQM_EXIT_METHOD, `SFQM_DW15_LOW};

	// little-endian byte pick; unlisted addresses read as filler
	always_comb begin
		o_byte = `SFQM_CAP_FILL;
		if (i_addr[7:2] == 6'(`SFQM_CAP_DW14_ADDR >> 2)) begin
			o_byte = dw14[8*i_addr[1:0] +: 8];
		end else if (i_addr[7:2] == 6'(`SFQM_CAP_DW15_ADDR >> 2)) begin
			o_byte = dw15[8*i_addr[1:0] +: 8];
		end
	end

endmodule
`default_nettype wire

// ===== src/sfqm_top.sv
// serial flash device front end: status, quad enable, continuous quad read
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "sfqm_defines.svh"

// Behaviour
// - status-one read bit 0 shows busy
// - quad enable at status-two bit 1, advertised
// - status-two read returns quad enable flag
// - two-byte status write while not busy sets or clears flag
// - quad enable needed; A5h mode enters continuous
// - mode upper nibble A keeps continuous mode
// - mode 00h leaves after current read
// - eight clocks all-ones force continuous exit
// - other upper nibble means exit continuous mode
// - power down opcodes reported as FFh
// - power down unsupported bit reads one
// - exit delay unit reported as 64 us
// - exit delay count reported as all ones
// - hold and protect disable reported unsupported
// - reserved capability fields read as ones
// - busy polling method reported as legacy
module sfqm_top (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// software register port
	input wire logic [3:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	// serial link pins
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic [3:0] i_quad_data_lines,
	output logic [3:0] o_quad_data_lines,
	output logic [3:0] o_quad_data_lines_oe,
	// mode indication
	output logic o_quad_io_enable_flag,
	output logic o_cont_mode
);
	import sfqm_pkg::*;

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [2:0] sck_sync_q;
	logic [2:0] cs_sync_q;
	logic [3:0] dq_meta_q;
	logic [3:0] dq_sync_q;
	logic sck_rise;
	logic sck_fall;
	logic cs_fall;
	logic cs_idle;
	sfqm_state_t st_q;
	logic [4:0] cnt_q;
	logic cnt_last;
	logic [7:0] in_sh_q;
	logic [7:0] in_single;
	logic [7:0] in_quad;
	logic [23:0] addr_q;
	logic [7:0] out_sh_q;
	logic [3:0] ones_cnt_q;
	logic cont_q;
	logic cont_nxt_q;
	logic mode_seen_q;
	logic wip_q;
	logic qe_q;
	logic [7:0] cap_byte;
	logic quad_out;
	logic single_out;
	logic [7:0] stat1;
	logic [7:0] stat2;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// length of each counted phase in serial clocks
	function automatic logic [4:0] phase_len(input sfqm_state_t s);
		case (s)
			SFQM_CMD: phase_len = `SFQM_CMD_CLKS;
			SFQM_WSR: phase_len = `SFQM_WSR_CLKS;
			SFQM_SADR: phase_len = `SFQM_SADR_CLKS;
			SFQM_SDMY: phase_len = `SFQM_SDMY_CLKS;
			SFQM_QADR: phase_len = `SFQM_QADR_CLKS;
			SFQM_QMODE: phase_len = `SFQM_QMODE_CLKS;
			SFQM_QDMY: phase_len = `SFQM_QDMY_CLKS;
			SFQM_QDATA: phase_len = `SFQM_QBYTE_CLKS;
			default: phase_len = `SFQM_SBYTE_CLKS;
		endcase
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// two flops per pin; the third bit only remembers the last level
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			sck_sync_q <= 3'b000;
			cs_sync_q <= 3'b111;
			dq_meta_q <= 4'h0;
			dq_sync_q <= 4'h0;
		end else begin
			sck_sync_q <= {sck_sync_q[1:0], i_sck};
			cs_sync_q <= {cs_sync_q[1:0], i_cs_n};
			dq_meta_q <= i_quad_data_lines;
			dq_sync_q <= dq_meta_q;
		end
	end

	// data pass the same depth as the clock, so they stay aligned
	assign sck_rise = sck_sync_q[1] & ~sck_sync_q[2];
	assign sck_fall = ~sck_sync_q[1] & sck_sync_q[2];
	assign cs_fall = ~cs_sync_q[1] & cs_sync_q[2];
	assign cs_idle = cs_sync_q[1];

	// ------------------------------------------------------------
	// shift paths and decode
	// ------------------------------------------------------------
	assign cnt_last = (cnt_q == phase_len(st_q) - 5'd1);
	assign in_single = {in_sh_q[6:0], dq_sync_q[0]};
	assign in_quad = {in_sh_q[3:0], dq_sync_q};
	assign stat1 = 8'h00 | (8'h01 << `SFQM_WIP_BIT); // position mask
	assign stat2 = 8'h00 | (8'h01 << `SFQM_QE_BIT);
	assign quad_out = (st_q == SFQM_QDATA);
	assign single_out = (st_q == SFQM_RD1) | (st_q == SFQM_RD2) | (st_q == SFQM_SDATA);

	// capability table lookup
	sfqm_caps_rom u_caps_rom (
		.i_addr(addr_q[7:0]),
		.o_byte(cap_byte)
	);

	// ------------------------------------------------------------
	// serial transaction sequencer
	// ------------------------------------------------------------
	// phase state, counters and shift registers move on sampled edges
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_q <= SFQM_IDLE;
			cnt_q <= 5'd0;
			in_sh_q <= 8'h00;
			addr_q <= 24'h00_0000;
			out_sh_q <= 8'h00;
			ones_cnt_q <= 4'h0;
			cont_nxt_q <= 1'b0;
			mode_seen_q <= 1'b0;
		end else if (cs_fall) begin
			// continuous mode skips the opcode entirely
			st_q <= cont_q ? SFQM_QADR : SFQM_CMD;
			cnt_q <= 5'd0;
			ones_cnt_q <= 4'h0;
			mode_seen_q <= 1'b0;
		end else if (cs_idle) begin
			st_q <= SFQM_IDLE;
		end else if (sck_rise) begin
			cnt_q <= cnt_last ? 5'd0 : cnt_q + 5'd1;
			case (st_q)
				SFQM_CMD: begin
					in_sh_q <= in_single;
					if (cnt_last) begin
						case (in_single)
							`SFQM_OP_RD_STAT1: begin
								st_q <= SFQM_RD1;
								out_sh_q <= wip_q ? stat1 : 8'h00;
							end
							`SFQM_OP_RD_STAT2: begin
								st_q <= SFQM_RD2;
								out_sh_q <= qe_q ? stat2 : 8'h00;
							end
							`SFQM_OP_WR_STAT: begin
								st_q <= SFQM_WSR;
							end
							`SFQM_OP_RD_CAPS: begin
								st_q <= SFQM_SADR;
							end
							`SFQM_OP_QUAD_RD: begin
								// quad read refused while quad lines are off
								st_q <= qe_q ? SFQM_QADR : SFQM_SKIP;
							end
							default: begin
								st_q <= SFQM_SKIP;
							end
						endcase
					end
				end
				SFQM_RD1: begin
					// status repeats for as long as the host clocks
					if (cnt_last) begin
						out_sh_q <= wip_q ? stat1 : 8'h00;
					end
				end
				SFQM_RD2: begin
					if (cnt_last) begin
						out_sh_q <= qe_q ? stat2 : 8'h00;
					end
				end
				SFQM_WSR: begin
					in_sh_q <= in_single;
					if (cnt_last) begin
						st_q <= SFQM_SKIP;
					end
				end
				SFQM_SADR: begin
					addr_q <= {addr_q[22:0], dq_sync_q[0]};
					if (cnt_last) begin
						st_q <= SFQM_SDMY;
					end
				end
				SFQM_SDMY: begin
					if (cnt_last) begin
						st_q <= SFQM_SDATA;
						out_sh_q <= cap_byte;
						addr_q <= addr_q + 24'h00_0001;
					end
				end
				SFQM_SDATA: begin
					if (cnt_last) begin
						out_sh_q <= cap_byte;
						addr_q <= addr_q + 24'h00_0001;
					end
				end
				SFQM_QADR, SFQM_QMODE: begin
					addr_q <= (st_q == SFQM_QADR) ? {addr_q[19:0], dq_sync_q} : addr_q;
					in_sh_q <= in_quad;
					// all-ones on every line counts toward a forced exit
					if (cont_q && dq_sync_q == `SFQM_EXIT_NIB) begin
						ones_cnt_q <= ones_cnt_q + 4'h1;
					end
					if (cont_q && dq_sync_q == `SFQM_EXIT_NIB &&
						ones_cnt_q == `SFQM_EXIT_CLKS - 4'h1) begin
						cont_nxt_q <= 1'b0;
						mode_seen_q <= 1'b1;
						st_q <= SFQM_SKIP;
					end else if (cnt_last && st_q == SFQM_QADR) begin
						st_q <= SFQM_QMODE;
					end else if (cnt_last) begin
						// A5h, or any Ax, keeps the mode; else leave
						cont_nxt_q <= (in_quad[7:4] == `SFQM_MODE_STAY_NIB);
						mode_seen_q <= 1'b1;
						st_q <= SFQM_QDMY;
					end
				end
				SFQM_QDMY: begin
					if (cnt_last) begin
						st_q <= SFQM_QDATA;
						out_sh_q <= addr_q[7:0];
						addr_q <= addr_q + 24'h00_0001;
					end
				end
				SFQM_QDATA: begin
					// no array here: each byte echoes its address
					if (cnt_last) begin
						out_sh_q <= addr_q[7:0];
						addr_q <= addr_q + 24'h00_0001;
					end
				end
				default: begin
					st_q <= st_q;
				end
			endcase
		end else if (sck_fall) begin
			// the bits just driven leave the shifter
			if (quad_out) begin
				out_sh_q <= {out_sh_q[3:0], 4'h0};
			end else if (single_out) begin
				out_sh_q <= {out_sh_q[6:0], 1'b0};
			end
		end
	end

	// ------------------------------------------------------------
	// quad enable flag
	// ------------------------------------------------------------
	// bit 1 of the second data byte decides; refused while busy
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			qe_q <= 1'b0;
		end else if (sck_rise && !cs_idle && st_q == SFQM_WSR && cnt_last && !wip_q) begin
			qe_q <= in_single[`SFQM_QE_BIT];
		end
	end

	// ------------------------------------------------------------
	// continuous mode flag
	// ------------------------------------------------------------
	// updated only when the access ends, so the current read finishes
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			cont_q <= 1'b0;
		end else if (cs_idle && mode_seen_q) begin
			cont_q <= cont_nxt_q;
		end
	end

	// ------------------------------------------------------------
	// data line drivers
	// ------------------------------------------------------------
	// change after the falling edge so the host samples on the rise
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_quad_data_lines <= 4'h0;
			o_quad_data_lines_oe <= 4'h0;
		end else if (cs_idle) begin
			o_quad_data_lines_oe <= 4'h0;
		end else if (sck_fall) begin
			if (quad_out) begin
				o_quad_data_lines <= out_sh_q[7:4];
				o_quad_data_lines_oe <= 4'hF;
			end else if (single_out) begin
				o_quad_data_lines <= {2'b00, out_sh_q[7], 1'b0};
				o_quad_data_lines_oe <= 4'h2;
			end else begin
				o_quad_data_lines_oe <= 4'h0;
			end
		end
	end

	// ------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------
	// busy flag stands in for the embedded operation engine
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			wip_q <= 1'b0;
		end else if (i_reg_wr && i_reg_addr == `SFQM_REG_CTRL) begin
			wip_q <= i_reg_wdata[`SFQM_WIP_BIT];
		end
	end

	// read data stand one cycle, zero otherwise and for unmapped offsets
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_rd && i_reg_addr == `SFQM_REG_CTRL) begin
			o_reg_rdata <= wip_q ? stat1 : 8'h00;
		end else if (i_reg_rd && i_reg_addr == `SFQM_REG_STATE) begin
			o_reg_rdata <= {5'b0_0000, cont_q, qe_q, wip_q};
		end else begin
			o_reg_rdata <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// mode indication
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_quad_io_enable_flag <= 1'b0;
			o_cont_mode <= 1'b0;
		end else begin
			o_quad_io_enable_flag <= qe_q;
			o_cont_mode <= cont_q;
		end
	end

endmodule
`default_nettype wire

// ===== dv/sfqm_top_props.sv
// assertion checker for the serial flash front end ports
`timescale 1ns/1ps
`default_nettype none
module sfqm_top_props (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// register port
	input wire logic [3:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] o_reg_rdata,
	// serial link and mode
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic [3:0] o_quad_data_lines,
	input wire logic [3:0] o_quad_data_lines_oe,
	input wire logic o_quad_io_enable_flag,
	input wire logic o_cont_mode
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	// ----
	// register answers
	// ----
	AST_RDATA_IDLE: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
		else $error("read data not idle");
	AST_CTRL_ECHO: assert property ((i_reg_wr && i_reg_addr == 4'h0) ##1
		(i_reg_rd && i_reg_addr == 4'h0) |=> o_reg_rdata[0] == $past(i_reg_wdata[0], 2))
		else $error("busy bit not echoed");
	AST_STATE_QE: assert property ($past(i_reg_rd) && $past(i_reg_addr) == 4'h4 && i_cs_n
		|-> o_reg_rdata[1] == o_quad_io_enable_flag && o_reg_rdata[7:3] == 5'h00)
		else $error("state read disagrees with flag");
	AST_UNMAPPED_ZERO: assert property ($past(i_reg_rd) &&
		!($past(i_reg_addr) inside {4'h0, 4'h4}) |-> o_reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	// ----
	// link and mode
	// ----
	AST_CONT_NEEDS_QE: assert property ($rose(o_cont_mode) |-> o_quad_io_enable_flag)
		else $error("continuous mode without quad enable");
	AST_CONT_AT_CS_HIGH: assert property ($changed(o_cont_mode) |-> i_cs_n && $past(i_cs_n, 2))
		else $error("mode changed inside a frame");
	AST_OE_IDLE: assert property (i_cs_n [*6] |-> o_quad_data_lines_oe == 4'h0)
		else $error("lines driven while deselected");
	AST_QUAD_NEEDS_QE: assert property (o_quad_data_lines_oe == 4'hF |-> o_quad_io_enable_flag)
		else $error("quad drive without quad enable");
	AST_OUT_ON_LOW: assert property ($changed(o_quad_data_lines) |-> !i_sck)
		else $error("output changed while clock high");
endmodule
bind sfqm_top sfqm_top_props u_props (
	.i_core_clk(i_core_clk),
	.i_rst(i_rst),
	.i_reg_addr(i_reg_addr),
	.i_reg_wdata(i_reg_wdata),
	.i_reg_wr(i_reg_wr),
	.i_reg_rd(i_reg_rd),
	.o_reg_rdata(o_reg_rdata),
	.i_sck(i_sck),
	.i_cs_n(i_cs_n),
	.o_quad_data_lines(o_quad_data_lines),
	.o_quad_data_lines_oe(o_quad_data_lines_oe),
	.o_quad_io_enable_flag(o_quad_io_enable_flag),
	.o_cont_mode(o_cont_mode)
);
`default_nettype wire

// ===== dv/sfqm_host_model.sv
// host flash controller model driving the serial link
`timescale 1ns/1ps
`default_nettype none
module sfqm_host_model (
	// pacing clock
	input wire logic i_clk,
	// link pins
	output logic o_sck,
	output logic o_cs_n,
	output logic [3:0] o_dq,
	input wire logic [3:0] i_dq
);
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_dq = 4'h0;
	end
	// half a serial clock: four core cycles, 800 ns period
	task automatic half;
		repeat (4) @(posedge i_clk);
	endtask
	task automatic start;
		o_cs_n <= 1'b0;
		half;
	endtask
	// clock idles low; released lines flip so stale data never reads back
	task automatic stop;
		half;
		o_cs_n <= 1'b1;
		o_dq <= ~o_dq;
		half;
		half;
	endtask
	// one clock: lines in mask m driven, the rest flipped; sample at the core edge of the rise
	task automatic clk1(input logic [3:0] n, input logic [3:0] m, output logic [3:0] r);
		o_dq <= (n & m) | (~o_dq & ~m);
		half;
		r = i_dq;
		o_sck <= 1'b1;
		half;
		o_sck <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== dv/sfqm_top_test.sv
// self-checking testbench of the serial flash front end
`timescale 1ns/1ps
`default_nettype none
`include "sfqm_defines.svh"
module sfqm_top_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] ra = 4'h0;
	logic [7:0] rwd = 8'h00;
	logic rwr = 1'b0;
	logic rrd = 1'b0;
	logic [7:0] rdata, v, x;
	logic sck, csn, qe, cont;
	logic [3:0] hdq, dout, oe, line;
	int n_fail = 0;
	int checked = 0;
	int cyc = 0;
	// host yields every line the device drives
	assign line = (oe & dout) | (~oe & hdq);
	always #50 clk = ~clk;
	sfqm_top u_dut (.i_core_clk(clk), .i_rst(rst), .i_reg_addr(ra), .i_reg_wdata(rwd),
		.i_reg_wr(rwr), .i_reg_rd(rrd), .o_reg_rdata(rdata), .i_sck(sck), .i_cs_n(csn),
		.i_quad_data_lines(line), .o_quad_data_lines(dout), .o_quad_data_lines_oe(oe),
		.o_quad_io_enable_flag(qe), .o_cont_mode(cont));
	sfqm_host_model u_host (.i_clk(clk), .o_sck(sck), .o_cs_n(csn), .o_dq(hdq), .i_dq(line));
	// ----
	// shared tasks
	// ----
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// register tasks start just after an edge, so back to back strobes abut
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		ra <= a;
		rwd <= d;
		rwr <= 1'b1;
		@(posedge clk);
		rwr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		ra <= a;
		rrd <= 1'b1;
		@(posedge clk);
		rrd <= 1'b0;
		// take the answer mid-cycle, then hand back on a rising edge
		@(negedge clk);
		d = rdata;
		@(posedge clk);
	endtask
	task automatic sb(input logic [7:0] b, output logic [7:0] r);
		logic [3:0] n;
		for (int i = 7; i >= 0; i--) begin
			u_host.clk1({3'h0, b[i]}, 4'h1, n);
			r = {r[6:0], n[1]};
		end
	endtask
	task automatic qb(input logic [7:0] b, input logic [3:0] m, output logic [7:0] r);
		logic [3:0] n;
		u_host.clk1(b[7:4], m, n);
		r[7:4] = n;
		u_host.clk1(b[3:0], m, n);
		r[3:0] = n;
	endtask
	task automatic sf(input logic [7:0] op, output logic [7:0] r);
		u_host.start;
		sb(op, x);
		sb(8'h00, r);
		u_host.stop;
	endtask
	task automatic wsr(input logic [7:0] b);
		u_host.start;
		sb(`SFQM_OP_WR_STAT, x);
		sb(8'h00, x);
		sb(b, x);
		u_host.stop;
	endtask
	// quad read; opcode left out while continuous mode is on
	task automatic qrd(input logic op, input logic [23:0] a, input logic [7:0] m, input logic on);
		logic c0;
		c0 = cont;
		u_host.start;
		if (op) sb(`SFQM_OP_QUAD_RD, x);
		for (int k = 2; k >= 0; k--) qb(a[8*k+:8], 4'hF, x);
		qb(m, 4'hF, x);
		repeat (2) qb(8'h00, 4'h0, x);
		for (int k = 0; k < 2; k++) begin
			qb(8'h00, 4'h0, v);
			if (on) chk("quad data", v, a[7:0] + 8'(k));
		end
		chk("quad oe", oe, on ? 4'hF : 4'h0);
		chk("mode held in frame", cont, c0);
		u_host.stop;
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_caps;
		logic [31:0] w [2];
		u_host.start;
		sb(`SFQM_OP_RD_CAPS, x);
		for (int k = 0; k < 3; k++) sb(k == 2 ? `SFQM_CAP_DW14_ADDR : 8'h00, x);
		sb(8'h00, x);
		for (int k = 0; k < 8; k++) begin
			sb(8'h00, v);
			w[k/4][8*(k%4)+:8] = v;
		end
		u_host.stop;
		chk("cap word 14", w[0], {1'h1, 8'hFF, 8'hFF, 2'h3, 5'h1F, 4'hF, 2'h1, 2'h3});
		chk("cap word 15", w[1], {8'hFF, 1'h0, 3'h5, 4'hD, `SFQM_EXIT_METHOD, `SFQM_DW15_LOW});
		$display("test caps done");
	endtask
	task automatic t_busy;
		wr(`SFQM_REG_CTRL, 8'h01);
		rd(`SFQM_REG_CTRL, v);
		chk("ctrl busy", v[0], 1'b1);
		sf(`SFQM_OP_RD_STAT1, v);
		chk("status busy", v[0], 1'b1);
		wsr(8'h02);
		sf(`SFQM_OP_RD_STAT2, v);
		chk("write while busy", v[1], 1'b0);
		wr(`SFQM_REG_CTRL, 8'h00);
		sf(`SFQM_OP_RD_STAT1, v);
		chk("status ready", v[0], 1'b0);
		$display("test busy done");
	endtask
	task automatic t_qe;
		wsr(8'h02);
		sf(`SFQM_OP_RD_STAT2, v);
		chk("qe set", v[1], 1'b1);
		rd(`SFQM_REG_STATE, v);
		chk("state", v, 8'h02);
		wsr(8'h00);
		sf(`SFQM_OP_RD_STAT2, v);
		chk("qe cleared", v[1], 1'b0);
		chk("qe pin", qe, 1'b0);
		$display("test qe done");
	endtask
	task automatic t_quad;
		logic [7:0] ex [3] = '{8'h5A, 8'hB5, 8'hFF};
		qrd(1'b1, 24'h00_0010, `SFQM_MODE_ENTER, 1'b0);
		chk("cont no qe", cont, 1'b0);
		wsr(8'h02);
		qrd(1'b1, 24'h01_0010, `SFQM_MODE_ENTER, 1'b1);
		chk("cont entered", cont, 1'b1);
		qrd(1'b0, 24'h00_00FE, 8'hA3, 1'b1);
		chk("cont kept", cont, 1'b1);
		qrd(1'b0, 24'h00_0020, `SFQM_MODE_EXIT, 1'b1);
		chk("cont left", cont, 1'b0);
		foreach (ex[i]) begin
			qrd(1'b1, 24'h00_0040, `SFQM_MODE_ENTER, 1'b1);
			qrd(1'b0, 24'h00_0041, ex[i], 1'b1);
			chk("cont other nibble", cont, 1'b0);
		end
		qrd(1'b1, 24'h00_0050, `SFQM_MODE_ENTER, 1'b1);
		u_host.start;
		repeat (4) qb(8'hFF, 4'hF, x);
		u_host.stop;
		chk("cont forced out", cont, 1'b0);
		qrd(1'b1, 24'h00_0060, `SFQM_MODE_EXIT, 1'b1);
		$display("test quad done");
	endtask
	task automatic t_regs;
		rd(4'h8, v);
		chk("unmapped", v, 8'h00);
		wr(`SFQM_REG_STATE, 8'hFF);
		rd(`SFQM_REG_STATE, v);
		chk("state read only", v, 8'h02);
		wr(`SFQM_REG_CTRL, 8'h01);
		$display("test regs done");
		t_caps;
	endtask
	// ----
	// main sequence and hang guard
	// ----
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("qe reset", qe, 1'b0);
		chk("cont reset", cont, 1'b0);
		t_caps;
		t_busy;
		t_qe;
		t_quad;
		t_regs;
		test_done;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			test_done;
		end
	end
endmodule
`default_nettype wire
